// File: rtl/macr_pkg.sv
// package for the management access configuration register bank
// assumes a single 100 MHz clock domain and a synchronous active-high reset
package macr_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [15:0] MACR_OFS_SERIAL_IO_CONTROL = 16'h0100;
  localparam logic [15:0] MACR_OFS_IN_BAND_ACCESS_CONTROL = 16'h0104;

  // ==========================================================
  // serial_io_control field positions and reset values
  localparam int MACR_SIO_PREAMBLE_SUPP_BIT = 2;
  localparam int MACR_SIO_AUTO_EDGE_BIT = 1;
  localparam int MACR_SIO_MANUAL_EDGE_BIT = 0;
  localparam int MACR_SIO_RSVD_LSB = 3;
  localparam int MACR_SIO_RSVD_MSB = 7;
  localparam logic [4:0] MACR_SIO_RSVD_RESET = 5'h08;
  localparam logic MACR_SIO_PREAMBLE_SUPP_RESET = 1'h0;
  localparam logic MACR_SIO_AUTO_EDGE_RESET = 1'h1;
  localparam logic MACR_SIO_MANUAL_EDGE_RESET = 1'h0;

  // ==========================================================
  // in_band_access_control field positions and reset values
  localparam int MACR_IBA_ENABLE_BIT = 31;
  localparam int MACR_IBA_MAC_MATCH_BIT = 30;
  localparam int MACR_IBA_RESET_BIT = 29;
  localparam int MACR_IBA_PRIO_LSB = 22;
  localparam int MACR_IBA_PRIO_MSB = 23;
  localparam int MACR_IBA_PORT_LSB = 16;
  localparam int MACR_IBA_PORT_MSB = 18;
  localparam int MACR_IBA_TPID_LSB = 0;
  localparam int MACR_IBA_TPID_MSB = 15;
  localparam logic MACR_IBA_MAC_MATCH_RESET = 1'h0;
  localparam logic [1:0] MACR_IBA_PRIO_RESET = 2'h1;
  localparam logic [2:0] MACR_IBA_PORT_RESET = 3'h0;
  localparam logic [15:0] MACR_IBA_TPID_RESET = 16'h40fe;
  localparam int MACR_NUM_PORTS = 3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        rd;     // read strobe, one cycle
    logic        wr;     // write strobe, one cycle
    logic [15:0] addr;   // byte address
    logic [3:0]  be;     // byte enables
    logic [31:0] wdata;  // write data
  } macr_req_t;

  typedef struct packed {
    logic        rvalid; // read data valid, one cycle
    logic [31:0] rdata;  // read data
  } macr_rsp_t;

  typedef struct packed {
    logic        enable;     // in-band access enabled
    logic        mac_match;  // destination mac check enabled
    logic        reset;      // one-cycle engine reinitialise
    logic [1:0]  prio;       // response transmit queue
    logic [2:0]  port_sel;   // one-hot port, zero for reserved codes
    logic [15:0] tpid;       // frame ethertype
  } macr_iba_cfg_t;

endpackage

// File: rtl/macr_regs.sv
// management access configuration register bank: serial i/o control and
// in-band access control, with strap capture of the in-band enable
// assumes register requests arrive on clk_sys; strap and speed inputs are async
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (RL1) clear suppression bit demands mdio preamble
// (RL2) suppression reaches only the mdio interface
// (RL3) auto mode: fast clock rising, slow falling
// (RL4) manual bit picks edge when auto off
// (RL5) manual bit ignored while auto on
// (RL6) enable loads inverted strap at reset
// (RL7) host keeps in-band off under i2c; done by the host model, not by this block
// (RL8) mac match bit gates destination check
// (RL9) reset bit pulses engine, self clears
// (RL10) priority field picks response queue
// (RL11) port field selects port, reserved none
// (RL12) tpid field sets recognised ethertype
module macr_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire macr_pkg::macr_req_t     reg_req,
  output var  macr_pkg::macr_rsp_t     reg_rsp,
  input  wire logic                    strap_led_pin,
  input  wire logic                    spi_clk_fast,
  output var  logic                    mdio_preamble_required,
  output var  logic                    serial_data_out_pin_rising,
  output var  macr_pkg::macr_iba_cfg_t in_band_access_cfg
);
  import macr_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic          strap_s1;   // strap synchroniser, first stage
    logic          strap_s2;   // strap synchroniser, second stage
    logic          strap_done; // strap captured since reset
    logic          spd_s1;     // clock speed synchroniser, first stage
    logic          spd_s2;     // clock speed synchroniser, second stage
    logic [4:0]    sio_rsvd;   // reserved but writable bits
    logic          supp;       // preamble suppression
    logic          auto_edge;  // automatic edge select
    logic          man_edge;   // manual edge select
    logic          en;         // in-band enable
    logic          mac;        // mac match enable
    logic          rst_bit;    // self clearing engine reset
    logic [1:0]    prio;       // response queue
    logic [2:0]    port;       // port code
    logic [15:0]   tpid;       // ethertype
    macr_rsp_t     rsp;        // registered read answer
    logic          pre_req;    // registered preamble demand
    logic          sdo_rise;   // registered launch edge
    macr_iba_cfg_t cfg;        // registered engine config
  } macr_state_t;

  macr_state_t st;       // current state
  macr_state_t next_st;  // next state

  logic wr_sio;  // write hits serial_io_control
  logic wr_iba;  // write hits in_band_access_control
  logic rd_sio;  // read hits serial_io_control
  logic rd_iba;  // read hits in_band_access_control

  // word-aligned decode; the low two address bits are ignored
  assign wr_sio = reg_req.wr && (reg_req.addr[15:2] == MACR_OFS_SERIAL_IO_CONTROL[15:2]);
  assign wr_iba = reg_req.wr && (reg_req.addr[15:2] == MACR_OFS_IN_BAND_ACCESS_CONTROL[15:2]);
  assign rd_sio = reg_req.rd && (reg_req.addr[15:2] == MACR_OFS_SERIAL_IO_CONTROL[15:2]);
  assign rd_iba = reg_req.rd && (reg_req.addr[15:2] == MACR_OFS_IN_BAND_ACCESS_CONTROL[15:2]);

  // ==========================================================
  // next-state logic
  always_comb begin
    next_st = st;
    // synchronisers run every cycle, reset or not, so the strap is settled
    next_st.strap_s1 = strap_led_pin;
    next_st.strap_s2 = st.strap_s1;
    next_st.spd_s1 = spi_clk_fast;
    next_st.spd_s2 = st.spd_s1;
    // self clearing: the pulse lasts one cycle unless rewritten
    next_st.rst_bit = 1'h0; // RL9
    // first cycle out of reset takes the inverted strap
    if (!st.strap_done) begin
      next_st.en = !st.strap_s2; // RL6
      next_st.strap_done = 1'h1;
    end
    // serial i/o control lives in byte lane 0
    if (wr_sio && reg_req.be[0]) begin
      next_st.sio_rsvd = reg_req.wdata[MACR_SIO_RSVD_MSB:MACR_SIO_RSVD_LSB];
      next_st.supp = reg_req.wdata[MACR_SIO_PREAMBLE_SUPP_BIT];
      next_st.auto_edge = reg_req.wdata[MACR_SIO_AUTO_EDGE_BIT];
      next_st.man_edge = reg_req.wdata[MACR_SIO_MANUAL_EDGE_BIT];
    end
    // in-band control, per byte lane
    if (wr_iba && reg_req.be[3]) begin
      next_st.en = reg_req.wdata[MACR_IBA_ENABLE_BIT];
      next_st.mac = reg_req.wdata[MACR_IBA_MAC_MATCH_BIT]; // RL8
      next_st.rst_bit = reg_req.wdata[MACR_IBA_RESET_BIT]; // RL9
    end
    if (wr_iba && reg_req.be[2]) begin
      next_st.prio = reg_req.wdata[MACR_IBA_PRIO_MSB:MACR_IBA_PRIO_LSB]; // RL10
      next_st.port = reg_req.wdata[MACR_IBA_PORT_MSB:MACR_IBA_PORT_LSB]; // RL11
    end
    if (wr_iba && reg_req.be[1]) begin
      next_st.tpid[15:8] = reg_req.wdata[15:8]; // RL12
    end
    if (wr_iba && reg_req.be[0]) begin
      next_st.tpid[7:0] = reg_req.wdata[7:0]; // RL12
    end
    // read answer one cycle after the strobe; unmapped reads return zero
    next_st.rsp.rvalid = reg_req.rd;
    next_st.rsp.rdata = 32'h0;
    if (rd_sio) begin
      next_st.rsp.rdata[MACR_SIO_RSVD_MSB:MACR_SIO_RSVD_LSB] = st.sio_rsvd;
      next_st.rsp.rdata[MACR_SIO_PREAMBLE_SUPP_BIT] = st.supp;
      next_st.rsp.rdata[MACR_SIO_AUTO_EDGE_BIT] = st.auto_edge;
      next_st.rsp.rdata[MACR_SIO_MANUAL_EDGE_BIT] = st.man_edge;
    end else if (rd_iba) begin
      next_st.rsp.rdata[MACR_IBA_ENABLE_BIT] = st.en;
      next_st.rsp.rdata[MACR_IBA_MAC_MATCH_BIT] = st.mac;
      next_st.rsp.rdata[MACR_IBA_RESET_BIT] = st.rst_bit;
      next_st.rsp.rdata[MACR_IBA_PRIO_MSB:MACR_IBA_PRIO_LSB] = st.prio;
      next_st.rsp.rdata[MACR_IBA_PORT_MSB:MACR_IBA_PORT_LSB] = st.port;
      next_st.rsp.rdata[MACR_IBA_TPID_MSB:MACR_IBA_TPID_LSB] = st.tpid;
    end
    // outputs follow the new register values in the same edge
    // suppression feeds only the mdio side; spi and i2c see nothing of it
    next_st.pre_req = !next_st.supp; // RL1 RL2
    // auto mode follows measured speed and never looks at the manual bit
    if (next_st.auto_edge) begin
      next_st.sdo_rise = next_st.spd_s2; // RL3 RL5
    end else begin
      next_st.sdo_rise = next_st.man_edge; // RL4
    end
    next_st.cfg.enable = next_st.en;
    next_st.cfg.mac_match = next_st.mac;
    next_st.cfg.reset = next_st.rst_bit;
    next_st.cfg.prio = next_st.prio;
    next_st.cfg.tpid = next_st.tpid;
    // reserved codes select no port rather than aliasing a real one
    case (next_st.port)
      3'h0:    next_st.cfg.port_sel = 3'h1; // RL11
      3'h1:    next_st.cfg.port_sel = 3'h2;
      3'h2:    next_st.cfg.port_sel = 3'h4;
      default: next_st.cfg.port_sel = 3'h0;
    endcase
    // reset values; synchroniser stages keep sampling
    if (rst) begin
      next_st.strap_done = 1'h0;
      next_st.sio_rsvd = MACR_SIO_RSVD_RESET;
      next_st.supp = MACR_SIO_PREAMBLE_SUPP_RESET;
      next_st.auto_edge = MACR_SIO_AUTO_EDGE_RESET;
      next_st.man_edge = MACR_SIO_MANUAL_EDGE_RESET;
      next_st.en = 1'h0;
      next_st.mac = MACR_IBA_MAC_MATCH_RESET;
      next_st.rst_bit = 1'h0;
      next_st.prio = MACR_IBA_PRIO_RESET;
      next_st.port = MACR_IBA_PORT_RESET;
      next_st.tpid = MACR_IBA_TPID_RESET;
      next_st.rsp = '0;
      next_st.pre_req = !MACR_SIO_PREAMBLE_SUPP_RESET;
      next_st.sdo_rise = 1'h0;
      next_st.cfg.enable = 1'h0;
      next_st.cfg.mac_match = MACR_IBA_MAC_MATCH_RESET;
      next_st.cfg.reset = 1'h0;
      next_st.cfg.prio = MACR_IBA_PRIO_RESET;
      next_st.cfg.port_sel = 3'h1;
      next_st.cfg.tpid = MACR_IBA_TPID_RESET;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign reg_rsp = st.rsp;
  assign mdio_preamble_required = st.pre_req;
  assign serial_data_out_pin_rising = st.sdo_rise;
  assign in_band_access_cfg = st.cfg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_preamble_write;
    (wr_sio && reg_req.be[0]) |=> (mdio_preamble_required == !$past(reg_req.wdata[2]));
  endproperty
  a_preamble_write: assert property (p_preamble_write) else $error("preamble demand wrong"); // RL1

  property p_preamble_only_sio;
    $changed(mdio_preamble_required) |-> $past(wr_sio && reg_req.be[0]);
  endproperty
  a_preamble_only_sio: assert property (p_preamble_only_sio) else $error("preamble moved"); // RL2

  // the launch edge tracks the synchronised speed level in the same cycle
  property p_auto_fast;
    (st.auto_edge && !wr_sio) ##1 st.spd_s2 |-> serial_data_out_pin_rising;
  endproperty
  a_auto_fast: assert property (p_auto_fast) else $error("fast clock not rising"); // RL3

  property p_manual_edge;
    (!st.auto_edge && !wr_sio) |=> (serial_data_out_pin_rising == $past(st.man_edge));
  endproperty
  a_manual_edge: assert property (p_manual_edge) else $error("manual edge ignored"); // RL4

  property p_auto_ignores_manual;
    (st.auto_edge && st.man_edge && !wr_sio) ##1 !st.spd_s2 |-> !serial_data_out_pin_rising;
  endproperty
  a_auto_ignores_manual: assert property (p_auto_ignores_manual) else $error("manual used"); // RL5

  property p_strap_load;
    $rose(st.strap_done) && !$past(wr_iba) |-> (st.en == !$past(st.strap_s2));
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded"); // RL6

  property p_mac_match;
    (wr_iba && reg_req.be[3]) |=> (in_band_access_cfg.mac_match == $past(reg_req.wdata[30]));
  endproperty
  a_mac_match: assert property (p_mac_match) else $error("mac match wrong"); // RL8

  property p_reset_pulse;
    (wr_iba && reg_req.be[3] && reg_req.wdata[29]) ##1 !(wr_iba && reg_req.be[3])
      |-> in_band_access_cfg.reset ##1 !in_band_access_cfg.reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset not self clearing"); // RL9

  property p_prio;
    (wr_iba && reg_req.be[2]) |=> (in_band_access_cfg.prio == $past(reg_req.wdata[23:22]));
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong"); // RL10

  property p_port;
    (st.port > 3'h2) |-> (in_band_access_cfg.port_sel == 3'h0);
  endproperty
  a_port: assert property (p_port) else $error("reserved port selected"); // RL11

  property p_tpid;
    (wr_iba && (reg_req.be[1:0] == 2'h3))
      |=> (in_band_access_cfg.tpid == $past(reg_req.wdata[MACR_IBA_TPID_MSB:MACR_IBA_TPID_LSB]));
  endproperty
  a_tpid: assert property (p_tpid) else $error("tpid wrong"); // RL12

  c_reset_pulse: cover property (in_band_access_cfg.reset);
  c_manual_rise: cover property (!st.auto_edge && serial_data_out_pin_rising);
  c_preamble_off: cover property (!mdio_preamble_required);
  c_port3: cover property (in_band_access_cfg.port_sel == 3'h4);

endmodule

`default_nettype wire

// File: dv/macr_host_model.sv
// host model: register bus master of the management access bank
// assumes reads are answered one cycle after the strobe edge
`timescale 1ns/1ns
`default_nettype none
module macr_host_model #(
  parameter bit I2C_HOST = 1'b0  // host manages the part over i2c
) (
  input  wire logic                clk_sys,
  output var  macr_pkg::macr_req_t reg_req,
  input  wire macr_pkg::macr_rsp_t reg_rsp
);
  import macr_pkg::*;
  // ==========================================================
  // bus tasks
  initial reg_req = '0;  // idle bus from time zero
  // one-cycle write strobe; released lines show the inverse, not stale data
  task automatic write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    if (I2C_HOST && a == MACR_OFS_IN_BAND_ACCESS_CONTROL) begin
      d[MACR_IBA_ENABLE_BIT] = 1'b0;
    end
    @(posedge clk_sys) #1;
    reg_req = '{1'b0, 1'b1, a, be, d};
    @(posedge clk_sys) #1;
    reg_req = '{1'b0, 1'b0, ~a, ~be, ~d};
  endtask
  // one-cycle read strobe, data taken at the edge where rvalid is high
  task automatic read(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys) #1;
    reg_req = '{1'b1, 1'b0, a, 4'hf, 32'h0};
    @(posedge clk_sys) #1;
    reg_req = '{1'b0, 1'b0, ~a, 4'h0, 32'hffffffff};
    d = 'x;  // a missing answer stays unknown and fails
    repeat (4) begin
      @(posedge clk_sys);
      if (reg_rsp.rvalid === 1'b1) begin
        d = reg_rsp.rdata;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench of the management access register bank
// assumes the host model drives the register bus; the bench owns pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import macr_pkg::*;
  // ==========================================================
  // signals
  logic          clk_sys;
  logic          rst;
  logic          strap_led_pin;
  logic          spi_clk_fast;
  macr_req_t     reg_req;
  macr_rsp_t     reg_rsp;
  logic          mdio_preamble_required;
  logic          serial_data_out_pin_rising;
  macr_iba_cfg_t in_band_access_cfg;
  int            error_cnt = 0;
  int            check_count = 0;
  int            seed = 32'hf282166f;  // fixed seed keeps runs repeatable
  logic [31:0]   d;
  logic [31:0]   v;
  logic [31:0]   e;
  // ==========================================================
  // clock, host and design
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  macr_host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rsp(reg_rsp));
  macr_regs uut (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .strap_led_pin(strap_led_pin), .spi_clk_fast(spi_clk_fast),
    .mdio_preamble_required(mdio_preamble_required),
    .serial_data_out_pin_rising(serial_data_out_pin_rising),
    .in_band_access_cfg(in_band_access_cfg));
  // ==========================================================
  // expectations
  function automatic logic [2:0] exp_port(input logic [2:0] c);
    return (c < 3'h3) ? (3'h1 << c) : 3'h0;  // reserved codes pick no port
  endfunction
  function automatic logic exp_sdo(input logic [1:0] s, input logic f);
    return s[1] ? f : s[0];  // auto mode follows the speed detector
  endfunction
  // verdict and end of run, shared with the watchdog
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // reset for 12 cycles with a given strap level
  task automatic do_reset(input logic s);
    @(posedge clk_sys) #1;
    rst = 1'b1;
    strap_led_pin = s;
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(mdio_preamble_required, 1'b1)
    `CHK(in_band_access_cfg, {3'h0, 2'h1, 3'h1, 16'h40fe})
    rst = 1'b0;
    @(posedge clk_sys) #1;
    `CHK(in_band_access_cfg.enable, ~s)
    host.read(16'h0100, d);
    `CHK(d, 32'h42)
    host.read(16'h0104, d);
    `CHK(d, {~s, 31'h004040fe})
  endtask
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    strap_led_pin = 1'b0;
    spi_clk_fast = 1'b0;
    do_reset(1'b0);
    do_reset(1'b1);
    $display("test reset done");
    // every mode combination with both speeds; sync takes 2 edges
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      e = {24'h0, v[7:3], i[2:0]};
      host.write(16'h0100, e, 4'h1);
      spi_clk_fast = i[3];
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK(mdio_preamble_required, ~i[2])
      `CHK(serial_data_out_pin_rising, exp_sdo(i[1:0], i[3]))
      host.read(16'h0100, d);
      `CHK(d, e)
    end
    $display("test serial io done");
    // random control words, each port code and a reset pulse
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      v[18:16] = i[2:0];
      // the first word always fires the engine reset pulse
      if (i == 0) begin
        v[29] = 1'b1;
      end
      host.write(16'h0104, v, 4'hf);
      e = {8'h0, v[31:30], v[29], v[23:22], exp_port(v[18:16]), v[15:0]};
      `CHK(in_band_access_cfg, e[23:0])
      @(posedge clk_sys) #1;
      `CHK(in_band_access_cfg.reset, 1'b0)
      host.read(16'h0104, d);
      `CHK(d, v & 32'hc0c7ffff)
    end
    $display("test in-band control done");
    // unmapped place and disabled lanes are refused; a lane 0 write changes only byte 0
    host.write(16'h0200, 32'hffffffff, 4'hf);
    host.read(16'h0200, d);
    `CHK(d, 32'h0)
    e = v & 32'hc0c7ffff;
    host.write(16'h0104, 32'h0, 4'h0);
    host.write(16'h0104, 32'h5a, 4'h1);
    host.read(16'h0104, d);
    `CHK(d, {e[31:8], 8'h5a})
    $display("test refusals done");
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
